//--- rtp_pkg.sv
/*
  Shared types and constants for the reset and test port pin block.
  Assumes a single system clock at 125 MHz; the test clock is sampled as data.
*/
`default_nettype none
package rtp_pkg;
  // Boot vector location in ROM
  localparam logic [23:0] RTP_RESET_VECTOR = 24'hFFFF00;
  localparam int RTP_IR_WIDTH = 4;
  localparam int RTP_DR_WIDTH = 32;
  localparam logic [3:0] RTP_IR_RESET = 4'h1;
  localparam logic [3:0] RTP_IR_BYPASS = 4'hF;
  localparam logic [3:0] RTP_IR_DATA = 4'h2;
  localparam logic [3:0] RTP_IR_SCAN = 4'h3;
  // Synchronised pins after reset: tck, tms, tdi, trst, reset pin
  localparam logic [4:0] RTP_SYNC_RESET = 5'h18;
  localparam logic [31:0] RTP_DR_RESET = 32'h0000_0000;
  // Bits of the pull inhibit register that this block honours
  localparam int RTP_PI_RESET_BIT = 0;
  localparam int RTP_PI_TMS_BIT = 1;
  localparam int RTP_PI_TDI_BIT = 2;
  localparam int RTP_PI_TCK_BIT = 3;

  typedef enum logic [3:0] {
    RTP_TLR = 4'h0, RTP_RTI = 4'h1, RTP_SEL_DR = 4'h2, RTP_CAP_DR = 4'h3,
    RTP_SHF_DR = 4'h4, RTP_EX1_DR = 4'h5, RTP_PAU_DR = 4'h6, RTP_EX2_DR = 4'h7,
    RTP_UPD_DR = 4'h8, RTP_SEL_IR = 4'h9, RTP_CAP_IR = 4'hA, RTP_SHF_IR = 4'hB,
    RTP_EX1_IR = 4'hC, RTP_PAU_IR = 4'hD, RTP_EX2_IR = 4'hE, RTP_UPD_IR = 4'hF
  } rtp_state_t;

  // Test port pins as seen from the device
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
  } rtp_jtag_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_b;
  } rtp_jtag_out_t;
endpackage : rtp_pkg
`default_nettype wire

//--- rtp_sync.sv
/*
  Three flop synchroniser bank with agreement filter.
  Assumes inputs are asynchronous to clk_sys_i.
*/
`timescale 1ns/1ns
`default_nettype none
module rtp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] reset_val_i,
  output logic [WIDTH-1:0] sync_o
);
  import rtp_pkg::*;
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  initial begin
    if (WIDTH < 1) $error("rtp_sync: WIDTH must be positive");
  end

  // Only s2_reg reads the first stage
  always_ff @(posedge clk_sys_i) begin
    meta_reg <= async_i;
    s2_reg <= meta_reg;
    s3_reg <= s2_reg;
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync_o <= reset_val_i;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_o[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : rtp_sync
`default_nettype wire

//--- rtp_port.sv
/*
  Device reset entry and serial test access port pins.
  Assumes all pins are asynchronous to clk_sys_i and that the test clock
  runs well below a quarter of the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - While reset is low, core is halted and program counter takes the vector.
// - On reset release, execution starts at the ROM vector leading to boot loader.
// - Reset pin pull-up follows inhibit bit, but is forced on during reset.
// - Test mode select pull-up is switched by the pull inhibit register.
// - Mode select sampled on each rising test clock edge; emulator keeps it valid.
// - Selected register shifts out on test data out at each falling edge.
// - Test data out floats except while a shift is in progress.
// - Flag output driven normally; floats only during a boundary scan.
// - Test data in captured on each rising test clock edge.
// - Test reset high lets scan logic take control of the device.
// - Test reset low keeps functional mode and ignores test inputs.
module rtp_port #(
  parameter int DR_WIDTH = rtp_pkg::RTP_DR_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic dev_reset_b_i,
  input wire logic [15:0] pull_resistor_inhibit_two_i,
  input wire rtp_pkg::rtp_jtag_in_t jtag_i,
  output rtp_pkg::rtp_jtag_out_t jtag_o,
  input wire logic flag_value_i,
  output logic external_flag_output_o,
  output logic external_flag_output_oe_b_o,
  output logic core_run_o,
  output logic [23:0] pc_load_o,
  output logic pc_load_en_o,
  output logic pu_reset_en_o,
  output logic pu_tms_en_o,
  output logic pu_tdi_en_o,
  output logic pu_tck_en_o,
  output logic test_ctrl_o,
  output logic [DR_WIDTH-1:0] dr_update_o,
  output logic dr_update_stb_o
);
  import rtp_pkg::*;

  initial begin
    if (DR_WIDTH < 2 || DR_WIDTH > 32) $error("rtp_port: DR_WIDTH must be 2 to 32");
  end

  logic [4:0] sync_q;
  logic tck_q, tms_q, tdi_q, trst_q, rst_pin_q;
  logic tck_prev_reg;
  logic tck_rise, tck_fall;
  rtp_state_t state_reg, state_next;
  logic [RTP_IR_WIDTH-1:0] ir_sh_reg, ir_reg;
  logic [DR_WIDTH-1:0] dr_sh_reg;
  logic byp_reg;
  logic shifting_reg;
  logic tdo_reg;
  logic rst_prev_reg;

  rtp_sync #(.WIDTH(5)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i({jtag_i.tck, jtag_i.tms, jtag_i.tdi, jtag_i.trst, dev_reset_b_i}),
    .reset_val_i(RTP_SYNC_RESET),
    .sync_o(sync_q)
  );
  assign {tck_q, tms_q, tdi_q, trst_q, rst_pin_q} = sync_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      // Same level as the synchronised clock after reset, so no false edge follows
      tck_prev_reg <= RTP_SYNC_RESET[4];
    end else begin
      tck_prev_reg <= tck_q;
    end
  end
  // Edges only count while test reset is high; low holds functional mode
  assign tck_rise = trst_q && tck_q && !tck_prev_reg;
  assign tck_fall = trst_q && !tck_q && tck_prev_reg;

  // Reset entry: core held and vector loaded while reset pin is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      core_run_o <= 1'b0;
      pc_load_en_o <= 1'b1;
      pc_load_o <= RTP_RESET_VECTOR;
      rst_prev_reg <= 1'b0;
    end else begin
      rst_prev_reg <= rst_pin_q;
      pc_load_o <= RTP_RESET_VECTOR;
      pc_load_en_o <= !rst_pin_q;
      core_run_o <= rst_pin_q && rst_prev_reg;
    end
  end

  // Pull-ups: inhibit bit high turns the resistor off, except the reset pull-up while the reset pin is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pu_reset_en_o <= 1'b1;
      pu_tms_en_o <= 1'b1;
      pu_tdi_en_o <= 1'b1;
      pu_tck_en_o <= 1'b1;
    end else begin
      pu_reset_en_o <= !rst_pin_q || !pull_resistor_inhibit_two_i[RTP_PI_RESET_BIT];
      pu_tms_en_o <= !pull_resistor_inhibit_two_i[RTP_PI_TMS_BIT];
      pu_tdi_en_o <= !pull_resistor_inhibit_two_i[RTP_PI_TDI_BIT];
      pu_tck_en_o <= !pull_resistor_inhibit_two_i[RTP_PI_TCK_BIT];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RTP_TLR: state_next = tms_q ? RTP_TLR : RTP_RTI;
      RTP_RTI: state_next = tms_q ? RTP_SEL_DR : RTP_RTI;
      RTP_SEL_DR: state_next = tms_q ? RTP_SEL_IR : RTP_CAP_DR;
      RTP_CAP_DR: state_next = tms_q ? RTP_EX1_DR : RTP_SHF_DR;
      RTP_SHF_DR: state_next = tms_q ? RTP_EX1_DR : RTP_SHF_DR;
      RTP_EX1_DR: state_next = tms_q ? RTP_UPD_DR : RTP_PAU_DR;
      RTP_PAU_DR: state_next = tms_q ? RTP_EX2_DR : RTP_PAU_DR;
      RTP_EX2_DR: state_next = tms_q ? RTP_UPD_DR : RTP_SHF_DR;
      RTP_UPD_DR: state_next = tms_q ? RTP_SEL_DR : RTP_RTI;
      RTP_SEL_IR: state_next = tms_q ? RTP_TLR : RTP_CAP_IR;
      RTP_CAP_IR: state_next = tms_q ? RTP_EX1_IR : RTP_SHF_IR;
      RTP_SHF_IR: state_next = tms_q ? RTP_EX1_IR : RTP_SHF_IR;
      RTP_EX1_IR: state_next = tms_q ? RTP_UPD_IR : RTP_PAU_IR;
      RTP_PAU_IR: state_next = tms_q ? RTP_EX2_IR : RTP_PAU_IR;
      RTP_EX2_IR: state_next = tms_q ? RTP_UPD_IR : RTP_SHF_IR;
      RTP_UPD_IR: state_next = tms_q ? RTP_SEL_DR : RTP_RTI;
      default: state_next = RTP_TLR;
    endcase
  end

  // Test reset low forces the controller back to its reset state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !trst_q) begin
      state_reg <= RTP_TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // Instruction path
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !trst_q) begin
      ir_sh_reg <= RTP_IR_RESET;
      ir_reg <= RTP_IR_RESET;
    end else if (tck_rise) begin
      case (state_reg)
        RTP_CAP_IR: ir_sh_reg <= RTP_IR_RESET;
        RTP_SHF_IR: ir_sh_reg <= {tdi_q, ir_sh_reg[RTP_IR_WIDTH-1:1]};
        RTP_UPD_IR: ir_reg <= ir_sh_reg;
        RTP_TLR: ir_reg <= RTP_IR_RESET;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Data path: a wide data register or the one-bit bypass
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !trst_q) begin
      dr_sh_reg <= RTP_DR_RESET[DR_WIDTH-1:0];
      byp_reg <= 1'b0;
      dr_update_o <= RTP_DR_RESET[DR_WIDTH-1:0];
      dr_update_stb_o <= 1'b0;
    end else begin
      dr_update_stb_o <= 1'b0;
      if (tck_rise) begin
        case (state_reg)
          RTP_CAP_DR: begin
            byp_reg <= 1'b0;
            dr_sh_reg <= dr_update_o;
          end
          RTP_SHF_DR: begin
            byp_reg <= tdi_q;
            dr_sh_reg <= {tdi_q, dr_sh_reg[DR_WIDTH-1:1]};
          end
          RTP_UPD_DR: begin
            if (ir_reg == RTP_IR_DATA || ir_reg == RTP_IR_SCAN) begin
              dr_update_o <= dr_sh_reg;
              dr_update_stb_o <= 1'b1;
            end
          end
          default: byp_reg <= byp_reg;
        endcase
      end
    end
  end

  // Output changes on the falling edge; driver on only while shifting
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !trst_q) begin
      tdo_reg <= 1'b0;
      shifting_reg <= 1'b0;
    end else if (tck_fall) begin
      shifting_reg <= (state_reg == RTP_SHF_DR) || (state_reg == RTP_SHF_IR);
      if (state_reg == RTP_SHF_IR) begin
        tdo_reg <= ir_sh_reg[0];
      end else if (ir_reg == RTP_IR_BYPASS || ir_reg == RTP_IR_RESET) begin
        tdo_reg <= byp_reg;
      end else begin
        tdo_reg <= dr_sh_reg[0];
      end
    end
  end
  assign jtag_o.tdo = tdo_reg;
  assign jtag_o.tdo_oe_b = !shifting_reg;

  // Flag pin floats only under the boundary-scan instruction
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      external_flag_output_o <= 1'b0;
      external_flag_output_oe_b_o <= 1'b0;
      test_ctrl_o <= 1'b0;
    end else begin
      external_flag_output_o <= flag_value_i;
      external_flag_output_oe_b_o <= trst_q && (ir_reg == RTP_IR_SCAN);
      test_ctrl_o <= trst_q;
    end
  end
endmodule : rtp_port
`default_nettype wire

//--- rtp_port_properties.sv
/* Checker for rtp_port, bound to it.
   Sees only its ports; one clock, clk_sys_i. */
`timescale 1ns/1ns
`default_nettype none
module rtp_port_properties (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic dev_reset_b_i,
  input wire logic [15:0] pull_resistor_inhibit_two_i,
  input wire rtp_pkg::rtp_jtag_in_t jtag_i,
  input wire rtp_pkg::rtp_jtag_out_t jtag_o,
  input wire logic external_flag_output_oe_b_o,
  input wire logic core_run_o,
  input wire logic pc_load_en_o,
  input wire logic pu_reset_en_o,
  input wire logic pu_tms_en_o,
  input wire logic test_ctrl_o,
  input wire logic dr_update_stb_o
);
  import rtp_pkg::*;
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  a_halt_in_reset: assert property (pc_load_en_o |-> !core_run_o)
    else $error("core runs in reset");
  a_run_on_release: assert property ($fell(pc_load_en_o) |=> core_run_o)
    else $error("no run after release");
  a_reset_pull_forced: assert property ((!dev_reset_b_i)[*8] |-> pu_reset_en_o && pc_load_en_o)
    else $error("reset pull-up off");
  a_tms_pull_follow: assert property ((rst_b_i && $stable(pull_resistor_inhibit_two_i))[*3]
    |-> pu_tms_en_o == !pull_resistor_inhibit_two_i[RTP_PI_TMS_BIT])
    else $error("tms pull-up wrong");
  // Sync delay is far shorter than half a test clock, so pin is still low
  a_tdo_on_fall: assert property ($changed(jtag_o) |-> !jtag_i.tck)
    else $error("tdo moved off fall");
  a_flag_float_scan: assert property (external_flag_output_oe_b_o |-> test_ctrl_o || $past(test_ctrl_o))
    else $error("flag floats");
  a_func_mode_quiet: assert property ((!test_ctrl_o)[*3]
    |-> jtag_o.tdo_oe_b && !external_flag_output_oe_b_o)
    else $error("port active in functional mode");
  a_update_pulse: assert property (dr_update_stb_o |-> test_ctrl_o && jtag_i.tck ##1 !dr_update_stb_o)
    else $error("bad update strobe");
endmodule : rtp_port_properties
bind rtp_port rtp_port_properties rtp_port_properties_i (.clk_sys_i, .rst_b_i, .dev_reset_b_i,
  .pull_resistor_inhibit_two_i, .jtag_i, .jtag_o, .external_flag_output_oe_b_o, .core_run_o,
  .pc_load_en_o, .pu_reset_en_o, .pu_tms_en_o, .test_ctrl_o, .dr_update_stb_o);
`default_nettype wire

//--- rtp_jtag_host.sv
/* Emulator model driving the test port pins.
   Test clock 125 ns, idle low between frames; tdo read at each rise. */
`timescale 1ns/1ns
`default_nettype none
module rtp_jtag_host (
  output var rtp_pkg::rtp_jtag_in_t pins_o,
  input wire rtp_pkg::rtp_jtag_out_t pins_i
);
  import rtp_pkg::*;
  initial pins_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst: 1'b0};
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_b);
    pins_o.tms = tms;
    pins_o.tdi = tdi;
    #31 pins_o.tck = 1'b1;
    tdo = pins_i.tdo;
    oe_b = pins_i.tdo_oe_b;
    #62 pins_o.tck = 1'b0;
    #32;
  endtask : step
  // Five ones reach reset from any state, then idle
  task automatic tap_reset(input logic trst);
    logic tdo, oe_b;
    pins_o.trst = trst;
    repeat (5) step(1'b1, 1'b1, tdo, oe_b);
    step(1'b0, 1'b1, tdo, oe_b);
  endtask : tap_reset
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_any, output logic oe_end);
    logic tdo, oe_b;
    oe_any = 1'b0;
    dout = '0;
    step(1'b1, 1'b0, tdo, oe_b);
    if (ir) step(1'b1, 1'b0, tdo, oe_b);
    step(1'b0, 1'b0, tdo, oe_b);
    step(1'b0, 1'b0, tdo, oe_b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], tdo, oe_b);
      dout[i] = tdo;
      oe_any = oe_any | oe_b;
    end
    step(1'b1, 1'b0, tdo, oe_b);
    step(1'b0, 1'b0, tdo, oe_end);
  endtask : scan
endmodule : rtp_jtag_host
`default_nettype wire

//--- rtp_port_tb_top.sv
/* Self-checking bench for rtp_port with an emulator model on the test port.
   Assumes package, synchroniser and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module rtp_port_tb_top;
  import rtp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic dev_reset_b_i = 1'b0;
  logic [15:0] pull_resistor_inhibit_two_i = 16'h0000;
  logic flag_value_i = 1'b0;
  rtp_jtag_in_t jtag_i;
  rtp_jtag_out_t jtag_o;
  logic external_flag_output_o, external_flag_output_oe_b_o, core_run_o, pc_load_en_o, pu_reset_en_o;
  logic pu_tms_en_o, pu_tdi_en_o, pu_tck_en_o, test_ctrl_o, dr_update_stb_o, oe_any, oe_end;
  logic [23:0] pc_load_o;
  logic [31:0] dr_update_o, got, word;
  logic [3:0] ir;
  logic [7:0] byte_in;
  int stb_seen = 0;
  int bad_count = 0;
  int checks_done = 0;
  rtp_port rtp_port_i (.clk_sys_i, .rst_b_i, .dev_reset_b_i, .pull_resistor_inhibit_two_i, .jtag_i,
    .jtag_o, .flag_value_i, .external_flag_output_o, .external_flag_output_oe_b_o, .core_run_o,
    .pc_load_o, .pc_load_en_o, .pu_reset_en_o, .pu_tms_en_o, .pu_tdi_en_o, .pu_tck_en_o,
    .test_ctrl_o, .dr_update_o, .dr_update_stb_o);
  rtp_jtag_host rtp_jtag_host_i (.pins_o(jtag_i), .pins_i(jtag_o));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  function automatic logic [2:0] pu_exp(input logic [15:0] p);
    return ~{p[RTP_PI_TCK_BIT], p[RTP_PI_TDI_BIT], p[RTP_PI_TMS_BIT]};
  endfunction : pu_exp
  // One-bit bypass delays the stream by one bit and leads with a zero
  function automatic logic [31:0] byp_exp(input logic [7:0] b);
    return {24'h000000, b[6:0], 1'b0};
  endfunction : byp_exp
  always @(posedge clk_sys_i) begin
    if (dr_update_stb_o === 1'b1) stb_seen++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // About 50 us of scans; four times that means a hang
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial begin
    got = $urandom(72);
    repeat (12) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk(pc_load_en_o, 1'b1);
    chk(pc_load_o, RTP_RESET_VECTOR);
    #1 dev_reset_b_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk({core_run_o, pc_load_en_o}, 2'b10);
    for (int k = 0; k < 8; k++) begin
      #1 pull_resistor_inhibit_two_i = (k == 0) ? 16'hFFFF : 16'($urandom);
      dev_reset_b_i = k[0];
      flag_value_i = 1'($urandom);
      repeat (12) @(posedge clk_sys_i);
      chk({pu_tck_en_o, pu_tdi_en_o, pu_tms_en_o}, pu_exp(pull_resistor_inhibit_two_i));
      chk(pu_reset_en_o, !pull_resistor_inhibit_two_i[RTP_PI_RESET_BIT] || !k[0]);
      chk({core_run_o, pc_load_en_o}, {k[0], !k[0]});
      chk(external_flag_output_o, flag_value_i);
    end
    rtp_jtag_host_i.tap_reset(1'b0);
    rtp_jtag_host_i.scan(1'b0, 8, $urandom, got, oe_any, oe_end);
    chk({oe_any, test_ctrl_o}, 2'b10);
    chk(dr_update_o, RTP_DR_RESET);
    rtp_jtag_host_i.tap_reset(1'b1);
    chk(test_ctrl_o, 1'b1);
    for (int j = 0; j < 4; j++) begin
      ir = j[0] ? RTP_IR_SCAN : RTP_IR_DATA;
      rtp_jtag_host_i.scan(1'b1, 4, 32'(ir), got, oe_any, oe_end);
      chk(got[3:0], 4'h1);
      chk({oe_any, oe_end}, 2'b01);
      chk(external_flag_output_oe_b_o, j[0]);
      word = (j == 0) ? 32'h8000_0001 : $urandom;
      rtp_jtag_host_i.scan(1'b0, 32, word, got, oe_any, oe_end);
      chk(dr_update_o, word);
      rtp_jtag_host_i.scan(1'b0, 32, ~word, got, oe_any, oe_end);
      chk(got, word);
    end
    rtp_jtag_host_i.scan(1'b1, 4, 32'(RTP_IR_BYPASS), got, oe_any, oe_end);
    chk(external_flag_output_oe_b_o, 1'b0);
    byte_in = 8'($urandom);
    rtp_jtag_host_i.scan(1'b0, 8, 32'(byte_in), got, oe_any, oe_end);
    chk(got, byp_exp(byte_in));
    chk(dr_update_o, ~word);
    chk(stb_seen, 32'd8);
    complete_run();
  end
endmodule : rtp_port_tb_top
`default_nettype wire
